// ===== rtl/pss_consts.svh
// constants for the power switchover and sync block
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_CLK_MHZ        100
`define PSS_DELAY_MS       3000
`define PSS_DELAY_CYC      (`PSS_DELAY_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_REF_HZ         38400
`define PSS_OSC_HALF_CYC   ((`PSS_CLK_MHZ * 1000000) / (2 * `PSS_REF_HZ))
`define PSS_MISS_PERIODS   4
`define PSS_SYNC_DIV       16
`define PSS_MID_DIV        2
`define PSS_SEL_UNIT1      1'b0
`endif

// ===== rtl/pss_fault_timer.sv
// sustained-fault delay counter firing one switchover pulse
`default_nettype none
module pss_fault_timer #(
    parameter int unsigned DELAY_CYC = 300000000
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic fault,
    output logic      fire
);
    localparam int unsigned CW = $clog2(DELAY_CYC + 1);
    pss_pkg::pss_tmr_t state_r;
    logic [CW-1:0]     cnt_r;

    // count while the fault holds; any break restarts from zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= pss_pkg::PSS_IDLE;
            cnt_r   <= '0;
            fire    <= 1'b0;
        end else if (clk_en) begin
            fire <= 1'b0;
            case (state_r)
                pss_pkg::PSS_IDLE: begin
                    cnt_r <= '0;
                    if (fault) begin
                        state_r <= pss_pkg::PSS_TIMING;
                        cnt_r   <= CW'(1);
                    end
                end
                pss_pkg::PSS_TIMING: begin
                    if (!fault) begin
                        state_r <= pss_pkg::PSS_IDLE;
                        cnt_r   <= '0;
                    end else if (cnt_r == CW'(DELAY_CYC)) begin
                        fire    <= 1'b1;
                        state_r <= pss_pkg::PSS_FIRED;
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
                pss_pkg::PSS_FIRED: begin
                    if (!fault) begin
                        state_r <= pss_pkg::PSS_IDLE;
                    end
                end
                default: state_r <= pss_pkg::PSS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pss_pkg.sv
// types for the power switchover and sync block
`default_nettype none
package pss_pkg;
    typedef enum logic [1:0] {PSS_IDLE, PSS_TIMING, PSS_FIRED} pss_tmr_t;
endpackage
`default_nettype wire

// ===== rtl/pss_top.sv
// redundancy switchover and inverter sync generation
// Contract
// - Regulator fault flags from separate under and over voltage inputs.
// - Regulator fault held for the delay moves selection to unit 2.
// - Automatic regulator switching only goes unit 1 to unit 2.
// - One latch drives input and output connect of each regulator together.
// - Commands may set or reset the regulator selection in any cycle with clk_en high; a fault firing in the same cycle beats a unit 1 command.
// - Inverter low for the delay with bus normal selects inverter 2.
// - Inverter switchover is suppressed if the bus is low at the drop.
// - Delay timer held inhibited while inverter output is normal.
// - Inverter switching never returns to unit 1; commands select either.
// - Sync outputs are timed from the external reference clock.
// - A local oscillator stands in while the reference is absent.
// - Selected reference divided by sixteen gives the single-phase sync.
// - That sync divided by two gives the three-phase intermediate clock.
// - Two flip-flop chain gives three phases at one third, equally spaced.
// - Sync outputs are fanned out to both redundant inverters.
`include "pss_consts.svh"
`default_nettype none
module pss_top #(
    parameter int unsigned DELAY_CYC    = `PSS_DELAY_CYC,
    parameter int unsigned OSC_HALF_CYC = `PSS_OSC_HALF_CYC,
    parameter int unsigned MISS_CYC     = 2 * `PSS_MISS_PERIODS
                                          * `PSS_OSC_HALF_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic bus_under_v,
    input  wire logic bus_over_v,
    input  wire logic cmd_reg_unit1,
    input  wire logic cmd_reg_unit2,
    input  wire logic inv24_low,
    input  wire logic inv400_low,
    input  wire logic cmd_inv24_unit1,
    input  wire logic cmd_inv24_unit2,
    input  wire logic cmd_inv400_unit1,
    input  wire logic cmd_inv400_unit2,
    input  wire logic ext_ref,
    output logic      reg1_connect,
    output logic      reg2_connect,
    output logic      inv24_1_on,
    output logic      inv24_2_on,
    output logic      inv400_1_on,
    output logic      inv400_2_on,
    output logic      backup_osc_used,
    output logic      sync24_inv1,
    output logic      sync24_inv2,
    output logic [2:0] ph400_inv1,
    output logic [2:0] ph400_inv2
);
    localparam int unsigned OW = $clog2(OSC_HALF_CYC + 1);
    localparam int unsigned MW = $clog2(MISS_CYC + 1);

    logic reg_fault;
    logic reg_fire;
    logic reg_sel_r;
    logic inv24_arm_r;
    logic inv400_arm_r;
    logic inv24_fire;
    logic inv400_fire;
    logic inv24_sel_r;
    logic inv400_sel_r;

    // regulator fault from either detector
    assign reg_fault = bus_under_v | bus_over_v;

    pss_fault_timer #(.DELAY_CYC(DELAY_CYC)) u_reg_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .fault    (reg_fault),
        .fire     (reg_fire)
    );

    // regulator selection latch; fault only sets unit 2 and beats a
    // unit 1 command landing in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_sel_r <= `PSS_SEL_UNIT1;
        end else if (clk_en) begin
            if (cmd_reg_unit2 || reg_fire) begin
                reg_sel_r <= 1'b1;
            end else if (cmd_reg_unit1) begin
                reg_sel_r <= 1'b0;
            end
        end
    end

    // both paths of a unit follow the one latch
    assign reg1_connect = ~reg_sel_r;
    assign reg2_connect = reg_sel_r;

    // inverter arm: set on the first low cycle with the bus normal, cleared when the output recovers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inv24_arm_r  <= 1'b0;
            inv400_arm_r <= 1'b0;
        end else if (clk_en) begin
            if (!inv24_low) begin
                inv24_arm_r <= 1'b0;
            end else if (!inv24_arm_r && !bus_under_v) begin
                inv24_arm_r <= 1'b1;
            end
            if (!inv400_low) begin
                inv400_arm_r <= 1'b0;
            end else if (!inv400_arm_r && !bus_under_v) begin
                inv400_arm_r <= 1'b1;
            end
        end
    end

    // a drop that started while the bus was low stays disarmed until cleared
    logic inv24_blk_r;
    logic inv400_blk_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inv24_blk_r  <= 1'b0;
            inv400_blk_r <= 1'b0;
        end else if (clk_en) begin
            if (!inv24_low) begin
                inv24_blk_r <= 1'b0;
            end else if (!inv24_arm_r && bus_under_v) begin
                inv24_blk_r <= 1'b1;
            end
            if (!inv400_low) begin
                inv400_blk_r <= 1'b0;
            end else if (!inv400_arm_r && bus_under_v) begin
                inv400_blk_r <= 1'b1;
            end
        end
    end

    pss_fault_timer #(.DELAY_CYC(DELAY_CYC)) u_inv24_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .fault    (inv24_arm_r & ~inv24_blk_r & ~bus_under_v),
        .fire     (inv24_fire)
    );

    pss_fault_timer #(.DELAY_CYC(DELAY_CYC)) u_inv400_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .fault    (inv400_arm_r & ~inv400_blk_r & ~bus_under_v),
        .fire     (inv400_fire)
    );

    // inverter selection latches
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inv24_sel_r  <= `PSS_SEL_UNIT1;
            inv400_sel_r <= `PSS_SEL_UNIT1;
        end else if (clk_en) begin
            if (cmd_inv24_unit2 || inv24_fire) inv24_sel_r <= 1'b1;
            else if (cmd_inv24_unit1) inv24_sel_r <= 1'b0;
            if (cmd_inv400_unit2 || inv400_fire) inv400_sel_r <= 1'b1;
            else if (cmd_inv400_unit1) inv400_sel_r <= 1'b0;
        end
    end

    assign inv24_1_on  = ~inv24_sel_r;
    assign inv24_2_on  = inv24_sel_r;
    assign inv400_1_on = ~inv400_sel_r;
    assign inv400_2_on = inv400_sel_r;

    // reference edge detect and local oscillator
    logic          ref_d_r;
    logic          ref_edge;
    logic          osc_r;
    logic [OW-1:0] osc_cnt_r;
    logic          osc_tick;
    logic [MW-1:0] miss_cnt_r;
    logic          missing_r;
    assign ref_edge = ext_ref & ~ref_d_r;
    assign osc_tick = (osc_cnt_r == OW'(OSC_HALF_CYC - 1)) & ~osc_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_d_r   <= 1'b0;
            osc_r     <= 1'b0;
            osc_cnt_r <= '0;
        end else if (clk_en) begin
            ref_d_r <= ext_ref;
            if (osc_cnt_r == OW'(OSC_HALF_CYC - 1)) begin
                osc_cnt_r <= '0;
                osc_r     <= ~osc_r;
            end else begin
                osc_cnt_r <= osc_cnt_r + OW'(1);
            end
        end
    end

    // missing detector: timeout since last reference edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            miss_cnt_r <= '0;
            missing_r  <= 1'b1;
        end else if (clk_en) begin
            if (ref_edge) begin
                miss_cnt_r <= '0;
                missing_r  <= 1'b0;
            end else if (miss_cnt_r == MW'(MISS_CYC)) begin
                missing_r <= 1'b1;
            end else begin
                miss_cnt_r <= miss_cnt_r + MW'(1);
            end
        end
    end

    assign backup_osc_used = missing_r;

    // one rising-edge tick from the chosen source; clean source change
    logic src_tick;
    assign src_tick = missing_r ? osc_tick : ref_edge;

    // divide by sixteen, then two, then three-phase ring
    logic [3:0] div16_r;
    logic       sync24_r;
    logic       mid_r;
    logic [1:0] ring_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div16_r  <= 4'h0;
            sync24_r <= 1'b0;
            mid_r    <= 1'b0;
            ring_r   <= 2'h0;
        end else if (clk_en && src_tick) begin
            div16_r <= div16_r + 4'h1;
            if (div16_r == 4'(`PSS_SYNC_DIV / 2 - 1)) begin
                sync24_r <= 1'b1;
            end else if (div16_r == 4'(`PSS_SYNC_DIV - 1)) begin
                sync24_r <= 1'b0;
                mid_r    <= ~mid_r;
                if (mid_r) begin
                    ring_r <= {ring_r[0], ~(ring_r[1] | ring_r[0])};
                end
            end
        end
    end

    // three phases: one-hot decode of the mod-3 ring, so every phase has
    // the same shape and each starts 120 deg after the one before
    logic [2:0] ph;
    assign ph = {ring_r[1], ring_r[0], ~(ring_r[1] | ring_r[0])};
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync24_inv1 <= 1'b0;
            sync24_inv2 <= 1'b0;
            ph400_inv1  <= 3'h0;
            ph400_inv2  <= 3'h0;
        end else if (clk_en) begin
            sync24_inv1 <= sync24_r;
            sync24_inv2 <= sync24_r;
            ph400_inv1  <= ph;
            ph400_inv2  <= ph;
        end
    end
endmodule
`default_nettype wire

// ===== verif/pss_checker.sv
// concurrent checks on the switchover and sync block ports
`default_nettype none
module pss_checker #(
    parameter int unsigned DELAY_CYC = 50,
    parameter int unsigned MISS_CYC  = 40
) (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic       bus_under_v,
    input wire logic       bus_over_v,
    input wire logic       cmd_reg_unit1,
    input wire logic       cmd_reg_unit2,
    input wire logic       cmd_inv24_unit1,
    input wire logic       cmd_inv400_unit1,
    input wire logic       ext_ref,
    input wire logic       reg1_connect,
    input wire logic       reg2_connect,
    input wire logic       inv24_1_on,
    input wire logic       inv400_1_on,
    input wire logic       backup_osc_used,
    input wire logic       sync24_inv1,
    input wire logic       sync24_inv2,
    input wire logic [2:0] ph400_inv1,
    input wire logic [2:0] ph400_inv2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] flt_r;
    logic [15:0] quiet_r;
    logic        ref_r;
    // run length of the bus fault and of a quiet reference line
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flt_r   <= 16'h0000;
            quiet_r <= 16'h0000;
            ref_r   <= 1'h0;
        end else begin
            ref_r   <= ext_ref;
            quiet_r <= (ext_ref != ref_r) ? 16'h0000 : quiet_r + 16'h0001;
            if (!(bus_under_v || bus_over_v)) flt_r <= 16'h0000;
            else if (clk_en) flt_r <= flt_r + 16'h0001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_REG_ONE_UNIT: assert property (reg1_connect != reg2_connect)
        else $error("regulator connects not complementary");
    AST_CMD_REG2: assert property (
        clk_en && cmd_reg_unit2 |=> reg2_connect)
        else $error("regulator 2 command ignored");
    AST_REG_NO_BACK: assert property (
        $rose(reg1_connect) |-> $past(cmd_reg_unit1))
        else $error("regulator 1 returned without command");
    AST_INV24_NO_BACK: assert property (
        $rose(inv24_1_on) |-> $past(cmd_inv24_unit1))
        else $error("inverter 24 unit 1 returned without command");
    AST_INV400_NO_BACK: assert property (
        $rose(inv400_1_on) |-> $past(cmd_inv400_unit1))
        else $error("inverter 400 unit 1 returned without command");
    AST_REG_DELAY: assert property (
        $rose(reg2_connect) && !$past(cmd_reg_unit2)
        |-> $past(flt_r) >= DELAY_CYC)
        else $error("regulator switched early");
    AST_SYNC_FANOUT: assert property (
        sync24_inv1 == sync24_inv2 && ph400_inv1 == ph400_inv2)
        else $error("sync copies differ");
    AST_OSC_TAKEOVER: assert property (
        quiet_r > MISS_CYC + 4 |-> backup_osc_used)
        else $error("local oscillator not taken over");
    // quiet_r has already been cleared by the edge that brought it back
    AST_REF_RETURN: assert property (
        $fell(backup_osc_used) |-> quiet_r < 16'h0004)
        else $error("reference taken back without edges");
    COV_REG_FAULT: cover property (
        $rose(reg2_connect) && !$past(cmd_reg_unit2));
    COV_INV_FAULT: cover property ($fell(inv24_1_on));
    COV_OSC_IN: cover property ($rose(backup_osc_used));
endmodule
bind pss_top pss_checker #(.DELAY_CYC(DELAY_CYC), .MISS_CYC(MISS_CYC))
    i_pss_checker (
    .core_clk, .rst_b, .clk_en, .bus_under_v, .bus_over_v, .cmd_reg_unit1,
    .cmd_reg_unit2, .cmd_inv24_unit1, .cmd_inv400_unit1, .ext_ref,
    .reg1_connect, .reg2_connect, .inv24_1_on, .inv400_1_on, .backup_osc_used,
    .sync24_inv1, .sync24_inv2, .ph400_inv1, .ph400_inv2);
`default_nettype wire

// ===== verif/pss_ref_src.sv
// reference clock source standing in for the sequencer clock
`default_nettype none
module pss_ref_src #(
    parameter int unsigned HALF_CYC = 4
) (
    input  wire logic core_clk,
    input  wire logic run,
    output var logic  ext_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt = 0;
    initial ext_ref = 1'h0;
    // square wave while running, parked low while the source is absent
    always @(posedge core_clk) begin
        cnt <= #1 (!run || cnt == HALF_CYC - 1) ? 0 : cnt + 1;
        if (!run) ext_ref <= #1 1'h0;
        else if (cnt == HALF_CYC - 1) ext_ref <= #1 ~ext_ref;
    end
endmodule
`default_nettype wire

// ===== verif/pss_top_tb_top.sv
// self-checking bench for the switchover and sync block
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module pss_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned D = 50;
    int num_errors = 0, checks_done = 0;
    logic core_clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, ref_run = 1'h0;
    logic bus_under_v = 1'h0, bus_over_v = 1'h0;
    logic [5:0] cmd = 6'h00;
    logic [1:0] low = 2'h0;
    logic [31:0] lf = 32'hAACD;
    logic reg1_connect, reg2_connect, inv24_1_on, inv24_2_on, inv400_1_on;
    logic inv400_2_on, backup_osc_used, sync24_inv1, sync24_inv2, ext_ref;
    logic [2:0] ph400_inv1, ph400_inv2;
    wire [5:0] sel = {reg1_connect, reg2_connect, inv24_1_on, inv24_2_on,
                      inv400_1_on, inv400_2_on};
    pss_top #(.DELAY_CYC(D), .OSC_HALF_CYC(4), .MISS_CYC(40)) i_pss_top (
        .core_clk, .rst_b, .clk_en, .bus_under_v, .bus_over_v,
        .cmd_reg_unit1(cmd[5]), .cmd_reg_unit2(cmd[4]), .inv24_low(low[1]),
        .inv400_low(low[0]), .cmd_inv24_unit1(cmd[3]),
        .cmd_inv24_unit2(cmd[2]), .cmd_inv400_unit1(cmd[1]),
        .cmd_inv400_unit2(cmd[0]), .ext_ref, .reg1_connect, .reg2_connect,
        .inv24_1_on, .inv24_2_on, .inv400_1_on, .inv400_2_on,
        .backup_osc_used, .sync24_inv1, .sync24_inv2, .ph400_inv1,
        .ph400_inv2);
    pss_ref_src #(.HALF_CYC(4)) i_pss_ref_src (.core_clk, .run(ref_run),
        .ext_ref);
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected selection after command k (even: unit 1, odd: unit 2)
    function automatic logic [5:0] apply(logic [5:0] s, int k);
        s[5 - 2 * (k / 2)] = ~k[0];
        s[4 - 2 * (k / 2)] = k[0];
        return s;
    endfunction
    // cycles for a count of reference periods of 8 cycles
    function automatic int per(int ticks);
        return ticks * 8;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(int b);
        cmd[b] = 1'h1;
        tick(1);
        cmd[b] = 1'h0;
        tick(1);
    endtask
    // cycles until the sync (ph=0) or phase (ph=1) output next changes
    task automatic gap(bit ph, output int n);
        logic [2:0] v;
        v = ph ? ph400_inv1 : {2'h0, sync24_inv1};
        n = 0;
        while ((ph ? ph400_inv1 : {2'h0, sync24_inv1}) === v) begin
            if (n > 2000) begin
                num_errors++;
                test_done();
            end
            tick(1);
            n++;
        end
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        test_done();
    end
    initial begin
        int n;
        int k;
        logic [5:0] exp;
        logic [2:0] p [3];
        tick(4);
        rst_b = 1'h1;
        `CHK(sel, 6'h2A)
        `CHK(backup_osc_used, 1'h1)
        ref_run = 1'h1;
        tick(30);
        `CHK(backup_osc_used, 1'h0)
        gap(0, n);
        gap(0, n);
        `CHK(n, per(8))
        `CHK(sync24_inv2, sync24_inv1)
        gap(1, n);
        for (int i = 0; i < 3; i++) begin
            p[i] = ph400_inv1;
            `CHK($onehot(p[i]), 1'h1)
            `CHK(ph400_inv2, p[i])
            gap(1, n);
            `CHK(n, per(32))
        end
        `CHK(ph400_inv1, p[0])
        `CHK(p[0] != p[1] && p[1] != p[2] && p[0] != p[2], 1'h1)
        ref_run = 1'h0;
        tick(50);
        `CHK(backup_osc_used, 1'h1)
        gap(0, n);
        gap(0, n);
        `CHK(n, per(8))
        ref_run = 1'h1;
        tick(30);
        `CHK(backup_osc_used, 1'h0)
        clk_en = 1'h0;
        cmd[4] = 1'h1;
        tick(2);
        cmd[4] = 1'h0;
        clk_en = 1'h1;
        tick(1);
        `CHK(reg1_connect, 1'h1)
        bus_under_v = 1'h1;
        tick(D - 1);
        bus_under_v = 1'h0;
        tick(5);
        `CHK(reg2_connect, 1'h0)
        bus_over_v = 1'h1;
        tick(D + 4);
        `CHK(reg2_connect, 1'h1)
        bus_over_v = 1'h0;
        tick(D + 4);
        `CHK(reg2_connect, 1'h1)
        pulse(5);
        bus_under_v = 1'h1;
        tick(D + 4);
        `CHK(sel[5:4], 2'h1)
        tick(1);
        low[1] = 1'h1;
        tick(5);
        bus_under_v = 1'h0;
        tick(D + 10);
        `CHK(inv24_2_on, 1'h0)
        low[1] = 1'h0;
        tick(2);
        for (int i = 0; i < 6; i++) begin
            lf = nxt(lf);
            low[0] = 1'h1;
            tick(1 + int'(lf % (D - 2)));
            low[0] = 1'h0;
            tick(3);
        end
        `CHK(inv400_2_on, 1'h0)
        low = 2'h3;
        tick(D + 6);
        `CHK(({inv24_2_on, inv400_2_on}), 2'h3)
        low = 2'h0;
        exp = 6'h15;
        for (int i = 0; i < 18; i++) begin
            lf = nxt(lf);
            k = (i < 6) ? i : int'(lf % 6);
            pulse(5 - k);
            exp = apply(exp, k);
            `CHK(sel, exp)
        end
        // both commands of every pair at once: unit 2 wins
        cmd = 6'h3F;
        tick(1);
        cmd = 6'h00;
        tick(1);
        `CHK(sel, 6'h15)
        rst_b = 1'h0;
        tick(1);
        `CHK(sel, 6'h2A)
        `CHK(backup_osc_used, 1'h1)
        rst_b = 1'h1;
        tick(2);
        test_done();
    end
endmodule
`default_nettype wire
